// ===== hdl/cpu_ctl_decode.sv
`timescale 1ns/1ps
module cpu_ctl_decode #(
    parameter int EA_CLKS = cpu_ctl_pkg::CLK_EA,
    parameter int WAIT_CLKS = cpu_ctl_pkg::CLK_WAIT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Instruction byte stream from the prefetch queue
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    // Processor pins and interrupt request
    input wire logic test_n,
    input wire logic intr,
    // Datapath register values
    input wire cpu_ctl_pkg::base_regs_t regs,
    // Decoded result to the execution unit
    output logic dec_valid,
    output cpu_ctl_pkg::decode_t dec,
    output logic [2:0] flags,
    output logic halted,
    // Register port
    input wire logic [cpu_ctl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    // Counter is three bits wide and counts down to one
    if (EA_CLKS < 2 || EA_CLKS > 7 || WAIT_CLKS < 2 || WAIT_CLKS > 7) begin : g_bad_counts
        $error("cpu_ctl_decode: cycle counts must lie in 2..7");
    end

    localparam logic [2:0] CTRL_CNT = 3'(cpu_ctl_pkg::CLK_CTRL - 1);
    localparam logic [2:0] NOP_CNT = 3'(cpu_ctl_pkg::CLK_NOP - 1);
    localparam logic [2:0] WAIT_CNT = 3'(WAIT_CLKS - 1);
    localparam logic [2:0] EA_CNT = 3'(EA_CLKS - 1);

    cpu_ctl_pkg::st_t s_q;
    cpu_ctl_pkg::st_t s_d;
    logic take;
    logic test_low;
    logic is_prefix;
    logic is_seg_prefix;
    logic is_string;
    logic [15:0] ea;
    logic [1:0] def_seg;

    cpu_ea_calc u_ea (
        .regs(regs),
        .mode(s_q.res.mode),
        .rm(s_q.res.rm),
        .disp(s_q.res.disp),
        .ea(ea),
        .def_seg(def_seg)
    );

    // Stream handshake: bytes are taken only in byte-consuming states
    assign in_ready = (s_q.state == cpu_ctl_pkg::S_OPC) || (s_q.state == cpu_ctl_pkg::S_MODRM)
        || (s_q.state == cpu_ctl_pkg::S_DLO) || (s_q.state == cpu_ctl_pkg::S_DHI);
    assign take = in_ready && in_valid;
    assign test_low = !s_q.test_sync;

    // Opcode classes
    assign is_seg_prefix = (in_byte[7:5] == cpu_ctl_pkg::PFX_TOP) && (in_byte[2:0] == cpu_ctl_pkg::PFX_LOW);
    assign is_prefix = is_seg_prefix || (in_byte == cpu_ctl_pkg::OP_LOCK);
    assign is_string = ((in_byte >= cpu_ctl_pkg::STR_A_LO) && (in_byte <= cpu_ctl_pkg::STR_A_HI))
        || ((in_byte >= cpu_ctl_pkg::STR_B_LO) && (in_byte <= cpu_ctl_pkg::STR_B_HI));

    // Outputs straight from state flops
    assign dec_valid = s_q.done;
    assign dec = s_q.res;
    assign flags = s_q.flags;
    assign halted = (s_q.state == cpu_ctl_pkg::S_HALT);
    assign reg_rdata = s_q.rdata;

    // Next-state logic for the whole decoder
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // Test pin is asynchronous; second stage is the only reader of the first
        s_d.test_meta = test_n;
        s_d.test_sync = s_q.test_meta;

        // Software write to flags; a flag opcode taken in the same cycle overrides the bit it sets
        if (reg_wr && reg_addr == cpu_ctl_pkg::REG_FLAGS) begin
            s_d.flags = reg_wdata[2:0];
        end

        // Register read data, valid in the following cycle only
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == cpu_ctl_pkg::REG_STATUS) begin
                s_d.rdata[2:0] = s_q.flags;
                s_d.rdata[cpu_ctl_pkg::STAT_HALTED] = (s_q.state == cpu_ctl_pkg::S_HALT);
                s_d.rdata[cpu_ctl_pkg::STAT_WAITING] = (s_q.state == cpu_ctl_pkg::S_WAIT);
                s_d.rdata[cpu_ctl_pkg::STAT_LOCK] = s_q.lock_pend;
                s_d.rdata[cpu_ctl_pkg::STAT_OVR] = s_q.ovr_valid;
            end else if (reg_addr == cpu_ctl_pkg::REG_FLAGS) begin
                s_d.rdata[2:0] = s_q.flags;
            end else if (reg_addr == cpu_ctl_pkg::REG_LAST_EA) begin
                s_d.rdata[15:0] = s_q.res.effective_operand_offset;
            end
        end

        case (s_q.state)
            cpu_ctl_pkg::S_OPC: begin
                if (take) begin
                    s_d.to_halt = 1'b0;
                    s_d.cnt = CTRL_CNT;
                    // Prefixes only arm state; everything else starts a new result
                    if (!is_prefix) begin
                        s_d.res = '0;
                        s_d.res.opcode = in_byte;
                        s_d.res.word = in_byte[0];
                        s_d.res.lock = s_q.lock_pend;
                        s_d.res.seg = s_q.ovr_valid ? s_q.ovr_seg : cpu_ctl_pkg::SEG_DATA;
                        s_d.res.dst_seg = cpu_ctl_pkg::SEG_EXTRA;
                        s_d.lock_pend = 1'b0;
                        s_d.ovr_valid = 1'b0;
                    end
                    s_d.state = cpu_ctl_pkg::S_EXEC;
                    if (in_byte == cpu_ctl_pkg::OP_CARRY_CLEAR) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_CF] = 1'b0;
                    end else if (in_byte == cpu_ctl_pkg::OP_CARRY_INVERT) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_CF] = !s_q.flags[cpu_ctl_pkg::FLAG_CF];
                    end else if (in_byte == cpu_ctl_pkg::OP_CARRY_SET) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_CF] = 1'b1;
                    end else if (in_byte == cpu_ctl_pkg::OP_DIR_CLEAR) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_DF] = 1'b0;
                    end else if (in_byte == cpu_ctl_pkg::OP_DIR_SET) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_DF] = 1'b1;
                    end else if (in_byte == cpu_ctl_pkg::OP_INTEN_CLEAR) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_IF] = 1'b0;
                    end else if (in_byte == cpu_ctl_pkg::OP_INTEN_SET) begin
                        s_d.flags[cpu_ctl_pkg::FLAG_IF] = 1'b1;
                    end else if (in_byte == cpu_ctl_pkg::OP_LOCK) begin
                        s_d.lock_pend = 1'b1;
                    end else if (is_seg_prefix) begin
                        s_d.ovr_valid = 1'b1;
                        s_d.ovr_seg = in_byte[4:3];
                    end else if (in_byte == cpu_ctl_pkg::OP_HALT) begin
                        s_d.to_halt = 1'b1;
                    end else if (in_byte == cpu_ctl_pkg::OP_WAIT) begin
                        // Already low: fixed count, otherwise park until it falls
                        s_d.cnt = WAIT_CNT;
                        if (!test_low) begin
                            s_d.state = cpu_ctl_pkg::S_WAIT;
                        end
                    end else if (in_byte == cpu_ctl_pkg::OP_NOP) begin
                        s_d.cnt = NOP_CNT;
                    end else if (is_string) begin
                        // Destination segment stays extra even with an override
                        s_d.res.is_string = 1'b1;
                        s_d.res.dst_seg = cpu_ctl_pkg::SEG_EXTRA;
                        s_d.cnt = CTRL_CNT;
                    end else begin
                        // Other opcodes are taken to carry an addressing byte
                        s_d.state = cpu_ctl_pkg::S_MODRM;
                        s_d.ovr_valid = s_q.ovr_valid; // Kept until the default segment is known
                    end
                end
            end

            cpu_ctl_pkg::S_WAIT: begin
                if (test_low) begin
                    s_d.cnt = WAIT_CNT;
                    s_d.state = cpu_ctl_pkg::S_EXEC;
                end
            end

            cpu_ctl_pkg::S_EXEC: begin
                if (s_q.cnt == 3'h1) begin
                    s_d.done = 1'b1;
                    s_d.state = s_q.to_halt ? cpu_ctl_pkg::S_HALT : cpu_ctl_pkg::S_OPC;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            cpu_ctl_pkg::S_HALT: begin
                // Only an interrupt request (or reset) resumes decoding
                if (intr) begin
                    s_d.state = cpu_ctl_pkg::S_OPC;
                end
            end

            cpu_ctl_pkg::S_MODRM: begin
                if (take) begin
                    s_d.res.mode = in_byte[7:6];
                    s_d.res.rm = in_byte[2:0];
                    // Byte registers: index 0..3, high half when top bit set
                    if (s_q.res.word) begin
                        s_d.res.gpr_index = in_byte[5:3];
                        s_d.res.gpr_hi_byte = 1'b0;
                    end else begin
                        s_d.res.gpr_index = {1'b0, in_byte[4:3]};
                        s_d.res.gpr_hi_byte = in_byte[5];
                    end
                    if (in_byte[7:6] == cpu_ctl_pkg::MOD_REG) begin
                        s_d.res.rm_is_reg = 1'b1;
                        s_d.ovr_valid = 1'b0;
                        s_d.done = 1'b1;
                        s_d.state = cpu_ctl_pkg::S_OPC;
                    end else begin
                        s_d.res.is_mem = 1'b1;
                        s_d.res.extra_clks = s_q.res.word ? cpu_ctl_pkg::WORD_XFER_EXTRA : 3'h0;
                        // Displacement bytes follow at once; immediates are left in the queue
                        if (in_byte[7:6] == cpu_ctl_pkg::MOD_NODISP && in_byte[2:0] != cpu_ctl_pkg::RM_DIRECT) begin
                            s_d.cnt = EA_CNT;
                            s_d.state = cpu_ctl_pkg::S_EA;
                        end else begin
                            s_d.state = cpu_ctl_pkg::S_DLO;
                        end
                    end
                end
            end

            cpu_ctl_pkg::S_DLO: begin
                if (take) begin
                    if (s_q.res.mode == cpu_ctl_pkg::MOD_DISP8) begin
                        s_d.res.disp = {{8{in_byte[7]}}, in_byte};
                        s_d.cnt = EA_CNT;
                        s_d.state = cpu_ctl_pkg::S_EA;
                    end else begin
                        s_d.res.disp[7:0] = in_byte;
                        s_d.state = cpu_ctl_pkg::S_DHI;
                    end
                end
            end

            cpu_ctl_pkg::S_DHI: begin
                if (take) begin
                    s_d.res.disp[15:8] = in_byte;
                    s_d.cnt = EA_CNT;
                    s_d.state = cpu_ctl_pkg::S_EA;
                end
            end

            cpu_ctl_pkg::S_EA: begin
                // Same cost in every mode; result and segment latched at the end
                if (s_q.cnt == 3'h1) begin
                    s_d.res.effective_operand_offset = ea;
                    // An override prefix beats the base-pointer default
                    if (!s_q.ovr_valid) begin
                        s_d.res.seg = def_seg;
                    end
                    s_d.ovr_valid = 1'b0;
                    s_d.done = 1'b1;
                    s_d.state = cpu_ctl_pkg::S_OPC;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            default: begin
                s_d.state = cpu_ctl_pkg::S_OPC;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.state <= cpu_ctl_pkg::S_OPC;
            s_q.flags <= cpu_ctl_pkg::FLAGS_RESET;
            s_q.test_meta <= 1'b1;
            s_q.test_sync <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // cpu_ctl_decode

// ===== hdl/cpu_ctl_pkg.sv
package cpu_ctl_pkg;

    // Processor-control opcodes
    localparam logic [7:0] OP_CARRY_CLEAR = 8'hF8;
    localparam logic [7:0] OP_CARRY_INVERT = 8'hF5;
    localparam logic [7:0] OP_CARRY_SET = 8'hF9;
    localparam logic [7:0] OP_DIR_CLEAR = 8'hFC;
    localparam logic [7:0] OP_DIR_SET = 8'hFD;
    localparam logic [7:0] OP_INTEN_CLEAR = 8'hFA;
    localparam logic [7:0] OP_INTEN_SET = 8'hFB;
    localparam logic [7:0] OP_HALT = 8'hF4;
    localparam logic [7:0] OP_WAIT = 8'h9B;
    localparam logic [7:0] OP_LOCK = 8'hF0;
    localparam logic [7:0] OP_NOP = 8'h90;

    // Segment override prefix pattern: 001 ss 110
    localparam logic [2:0] PFX_TOP = 3'h1;
    localparam logic [2:0] PFX_LOW = 3'h6;

    // String primitives: A4..A7 and AA..AF
    localparam logic [7:0] STR_A_LO = 8'hA4;
    localparam logic [7:0] STR_A_HI = 8'hA7;
    localparam logic [7:0] STR_B_LO = 8'hAA;
    localparam logic [7:0] STR_B_HI = 8'hAF;

    // Cycle counts
    localparam int CLK_CTRL = 2;
    localparam int CLK_WAIT = 6;
    localparam int CLK_NOP = 3;
    localparam int CLK_EA = 4;
    localparam logic [2:0] WORD_XFER_EXTRA = 3'h4;

    // Addressing-form field values
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP16 = 2'h2;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;

    // Segment codes
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_CODE = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;

    // Register port map
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_FLAGS = 4'h4;
    localparam logic [3:0] REG_LAST_EA = 4'h8;
    localparam int FLAG_CF = 0;
    localparam int FLAG_DF = 1;
    localparam int FLAG_IF = 2;
    localparam int STAT_HALTED = 3;
    localparam int STAT_WAITING = 4;
    localparam int STAT_LOCK = 5;
    localparam int STAT_OVR = 6;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // Base and index register values from the datapath
    typedef struct packed {
        logic [15:0] base_word_reg;
        logic [15:0] base_pointer;
        logic [15:0] src_index;
        logic [15:0] destination_index;
    } base_regs_t;

    // Decoded instruction handed to the execution unit
    typedef struct packed {
        logic [7:0] opcode;
        logic lock;
        logic is_mem;
        logic rm_is_reg;
        logic [1:0] mode;
        logic [2:0] rm;
        logic word;
        logic [2:0] gpr_index;
        logic gpr_hi_byte;
        logic [15:0] disp;
        logic [15:0] effective_operand_offset;
        logic [1:0] seg;
        logic is_string;
        logic [1:0] dst_seg;
        logic [2:0] extra_clks;
    } decode_t;

    typedef enum logic [7:0] {
        S_OPC = 8'h01,
        S_EXEC = 8'h02,
        S_HALT = 8'h04,
        S_WAIT = 8'h08,
        S_MODRM = 8'h10,
        S_DLO = 8'h20,
        S_DHI = 8'h40,
        S_EA = 8'h80
    } state_t;

    // Whole state of the decoder
    typedef struct packed {
        state_t state;
        logic [2:0] cnt;
        logic to_halt;
        logic [2:0] flags;
        logic lock_pend;
        logic ovr_valid;
        logic [1:0] ovr_seg;
        logic test_meta;
        logic test_sync;
        decode_t res;
        logic done;
        logic [31:0] rdata;
    } st_t;

endpackage

// ===== hdl/cpu_ea_calc.sv
`timescale 1ns/1ps
module cpu_ea_calc (
    // Register values and addressing fields
    input wire cpu_ctl_pkg::base_regs_t regs,
    input wire logic [1:0] mode,
    input wire logic [2:0] rm,
    input wire logic [15:0] disp,
    // Offset and default segment
    output logic [15:0] ea,
    output logic [1:0] def_seg
);
    logic [15:0] base;
    logic uses_bp;

    // Base sum per operand-select field; displacement always added
    always_comb begin
        base = 16'h0000;
        uses_bp = 1'b0;
        case (rm)
            3'h0: base = regs.base_word_reg + regs.src_index;
            3'h1: base = regs.base_word_reg + regs.destination_index;
            3'h2: begin
                base = regs.base_pointer + regs.src_index;
                uses_bp = 1'b1;
            end
            3'h3: begin
                base = regs.base_pointer + regs.destination_index;
                uses_bp = 1'b1;
            end
            3'h4: base = regs.src_index;
            3'h5: base = regs.destination_index;
            3'h6: begin
                base = regs.base_pointer;
                uses_bp = 1'b1;
            end
            default: base = regs.base_word_reg;
        endcase
        // Direct form: displacement alone, no base pointer involved
        if (mode == cpu_ctl_pkg::MOD_NODISP && rm == cpu_ctl_pkg::RM_DIRECT) begin
            base = 16'h0000;
            uses_bp = 1'b0;
        end
        ea = base + disp;
        def_seg = uses_bp ? cpu_ctl_pkg::SEG_STACK : cpu_ctl_pkg::SEG_DATA;
    end
endmodule // cpu_ea_calc

// ===== verification/cpu_ctl_decode_chk.sv
`timescale 1ns/1ps
module cpu_ctl_decode_chk #(
    parameter int EA_CLKS = 4,
    parameter int WAIT_CLKS = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Stream and pins
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_ready,
    input wire logic test_n,
    input wire logic intr,
    // Decoded result
    input wire logic dec_valid,
    input wire cpu_ctl_pkg::decode_t dec,
    input wire logic [2:0] flags,
    input wire logic halted
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Byte taken in the opcode slot; the bench never reuses these values as operand bytes
    sequence took(logic [7:0] b);
        in_valid && in_ready && in_byte == b;
    endsequence
    // Test pin low long enough to have crossed the synchroniser
    sequence test_settled;
        (!test_n) [*5];
    endsequence
    // A memory-form result; prefixes repeat stale contents, so they are kept out by the stall
    sequence mem_done;
        dec_valid && dec.is_mem && !dec.is_string && !$past(in_ready) && !$past(in_ready, 2);
    endsequence
    a_carry_set: assert property (took(8'hF9) |-> ##2 dec_valid && flags[0]) else $error("carry set late");
    a_carry_invert: assert property (took(8'hF5) |-> ##2 dec_valid && flags[0] != $past(flags[0], 2))
        else $error("carry not inverted");
    a_dir_flag: assert property (in_valid && in_ready && in_byte[7:1] == 7'h7E
        |-> ##2 dec_valid && flags[1] == $past(in_byte[0], 2)) else $error("direction flag wrong");
    a_int_flag: assert property (in_valid && in_ready && in_byte[7:1] == 7'h7D
        |-> ##2 dec_valid && flags[2] == $past(in_byte[0], 2)) else $error("int enable wrong");
    a_lock_cost: assert property (took(8'hF0) |-> ##1 !dec_valid ##1 dec_valid) else $error("lock cost");
    a_halt_entry: assert property (took(8'hF4) |-> ##2 dec_valid ##1 halted) else $error("halt entry");
    a_halt_hold: assert property (halted && !intr |=> halted && !in_ready) else $error("halt left");
    a_wait_six: assert property (test_settled ##0 took(8'h9B) |-> ##WAIT_CLKS dec_valid)
        else $error("wait length");
    a_ea_four: assert property (mem_done |-> $past(in_ready, EA_CLKS) && !$past(in_ready, EA_CLKS - 1))
        else $error("address time");
    a_reg_form: assert property (dec_valid && !dec.is_string && dec.mode == 2'h3 |-> dec.rm_is_reg && !dec.is_mem)
        else $error("register form");
    a_disp8_sext: assert property (dec_valid && dec.is_mem && dec.mode == 2'h1
        |-> dec.disp[15:8] == {8{dec.disp[7]}}) else $error("short offset sign");
    a_direct_disp: assert property (dec_valid && dec.is_mem && dec.mode == 2'h0 && dec.rm == 3'h6
        |-> dec.effective_operand_offset == dec.disp) else $error("direct offset");
endmodule // cpu_ctl_decode_chk

// ===== verification/pfq_model.sv
`timescale 1ns/1ps
module pfq_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Stream handshake
    input wire logic in_ready,
    input wire logic stall,
    output logic in_valid,
    output logic [7:0] in_byte
);
    logic [7:0] q[$];
    logic gap_q;
    // Bytes leave in program order: opcode, addressing byte, offset low then high
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // An offered byte holds until taken; idle lines toggle so no stale value reads as data
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            in_valid <= 1'b0;
            in_byte <= 8'h00;
            gap_q <= 1'b0;
        end else begin
            gap_q <= ~gap_q;
            if (in_valid && in_ready) begin
                void'(q.pop_front());
            end
            if (!in_valid || in_ready) begin
                if (q.size() > 0 && (!stall || gap_q)) begin
                    in_valid <= 1'b1;
                    in_byte <= q[0];
                end else begin
                    in_valid <= 1'b0;
                    in_byte <= ~in_byte;
                end
            end
        end
    end
endmodule // pfq_model

// ===== verification/test_cpu_ctl_decode.sv
`timescale 1ns/1ps
module test_cpu_ctl_decode;
    typedef struct packed {
        logic [31:0] code;
        logic [2:0] n;
        logic [15:0] ea;
        logic [1:0] seg;
    } row_t;
    // Stimulus, defined at time zero
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic stall = 1'b0;
    logic test_n = 1'b0;
    logic intr = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    // Expected sums below are worked by hand from these values
    cpu_ctl_pkg::base_regs_t regs = {16'h1000, 16'h2000, 16'h0030, 16'h0004};
    logic in_valid;
    logic in_ready;
    logic dec_valid;
    logic halted;
    logic [7:0] in_byte;
    logic [2:0] flags;
    logic [31:0] reg_rdata;
    cpu_ctl_pkg::decode_t dec;
    int miscompares = 0;
    int total_checks = 0;
    int pulses = 0;
    int cycles = 0;
    // Memory forms: bytes low first, count, offset, segment; the last row is byte wide
    row_t rows [13] = '{
        '{32'h0000008B, 3'd2, 16'h1030, 2'h3}, '{32'h0000018B, 3'd2, 16'h1004, 2'h3},
        '{32'h0080428B, 3'd3, 16'h1FB0, 2'h2}, '{32'h1234838B, 3'd4, 16'h3238, 2'h2},
        '{32'h007F448B, 3'd3, 16'h00AF, 2'h3}, '{32'hFFFE858B, 3'd4, 16'h0002, 2'h3},
        '{32'h5678068B, 3'd4, 16'h5678, 2'h3}, '{32'h0001468B, 3'd3, 16'h2001, 2'h2},
        '{32'h01468B26, 3'd4, 16'h2001, 2'h0}, '{32'h00078B2E, 3'd3, 16'h1000, 2'h1},
        '{32'h00078B36, 3'd3, 16'h1000, 2'h2}, '{32'h01468B3E, 3'd4, 16'h2001, 2'h3},
        '{32'h0000078A, 3'd2, 16'h1000, 2'h3}};
    cpu_ctl_decode #(.EA_CLKS(4), .WAIT_CLKS(6)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
        .test_n(test_n), .intr(intr), .regs(regs), .dec_valid(dec_valid), .dec(dec), .flags(flags),
        .halted(halted), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    pfq_model i_pfq (.sys_clk(sys_clk), .nrst(nrst), .in_ready(in_ready), .stall(stall),
        .in_valid(in_valid), .in_byte(in_byte));
    // Clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Count result pulses; the ceiling is several times the expected run
    always @(posedge sys_clk) begin
        if (dec_valid === 1'b1) pulses <= pulses + 1;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Queue pushes land on the falling edge, clear of the model's sampling
    task automatic feed(input logic [31:0] code, input int n);
        @(negedge sys_clk);
        for (int i = 0; i < n; i++) i_pfq.push(code[8*i +: 8]);
    endtask
    task automatic wait_dec(input int k);
        int tgt;
        tgt = pulses + k;
        for (int i = 0; i < 60 && pulses < tgt; i++) @(posedge sys_clk);
        #1;
        chk(pulses >= tgt, 1);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] rd;
        logic [7:0] opc;
        logic [2:0] fl;
        logic pfx;
        int p;
        logic [7:0] ops [9];
        ops = '{8'hF9, 8'hF5, 8'hF5, 8'hF8, 8'hFD, 8'hFC, 8'hFA, 8'hFB, 8'hF9};
        fl = 3'h0;
        repeat (3) @(posedge sys_clk);
        chk({in_ready, dec_valid, halted, flags}, 6'h20);
        chk(reg_rdata, 32'h0);
        nrst <= 1'b1;
        // Flag opcodes, expectations kept by a local flag copy
        foreach (ops[i]) begin
            feed(ops[i], 1);
            wait_dec(1);
            if (ops[i] == 8'hF5) fl[0] = ~fl[0];
            else if (ops[i][7:1] == 7'h7C) fl[0] = ops[i][0];
            else if (ops[i][7:1] == 7'h7E) fl[1] = ops[i][0];
            else fl[2] = ops[i][0];
            chk(flags, fl);
        end
        // Table of memory forms; odd rows come from a slow queue
        foreach (rows[r]) begin
            stall <= r[0];
            opc = rows[r].code[7:0];
            pfx = opc[7:5] == 3'h1 && opc[2:0] == 3'h6;
            if (pfx) opc = rows[r].code[15:8];
            feed(rows[r].code, rows[r].n);
            wait_dec(1 + pfx);
            chk(dec.effective_operand_offset, rows[r].ea);
            chk(dec.seg, rows[r].seg);
            chk({dec.is_mem, dec.extra_clks}, {1'b1, opc[0] ? 3'h4 : 3'h0});
        end
        stall <= 1'b0;
        // Register port, an unmapped place and a read-only place among them
        reg_read(cpu_ctl_pkg::REG_FLAGS, rd);
        chk(rd[2:0], fl);
        reg_read(cpu_ctl_pkg::REG_STATUS, rd);
        chk(rd[6:0], {4'h0, fl});
        reg_write(cpu_ctl_pkg::REG_FLAGS, 32'h2);
        chk(flags, 3'h2);
        reg_read(4'hC, rd);
        chk(rd, 32'h0);
        reg_write(cpu_ctl_pkg::REG_LAST_EA, 32'hBEEF);
        reg_read(cpu_ctl_pkg::REG_LAST_EA, rd);
        chk(rd[15:0], 16'h1000);
        // Register forms, both widths, every register code
        for (int c = 0; c < 16; c++) begin
            feed({16'h0, 2'h3, c[2:0], 3'h7, 7'h45, c[3]}, 2);
            wait_dec(1);
            chk({dec.rm_is_reg, dec.is_mem}, 2'b10);
            chk({dec.gpr_index[1:0], dec.gpr_hi_byte}, {c[1:0], c[3] ? 1'b0 : c[2]});
            if (c[3]) chk(dec.gpr_index, c[2:0]);
        end
        // Lock applies once, then clears
        feed(32'h00078BF0, 3);
        wait_dec(2);
        chk(dec.lock, 1'b1);
        feed(32'h0000078B, 2);
        wait_dec(1);
        chk(dec.lock, 1'b0);
        // Override ahead of a string move must not move its destination
        feed(32'h0000A52E, 2);
        wait_dec(2);
        chk({dec.is_string, dec.dst_seg}, {1'b1, cpu_ctl_pkg::SEG_EXTRA});
        // Halt with an instruction waiting behind it
        feed(32'h00078BF4, 3);
        wait_dec(1);
        repeat (8) @(posedge sys_clk);
        #1 chk({halted, in_ready}, 2'b10);
        @(posedge sys_clk);
        intr <= 1'b1;
        @(posedge sys_clk);
        intr <= 1'b0;
        wait_dec(1);
        chk(halted, 1'b0);
        // Wait held by the test pin, then again with the pin already low
        @(posedge sys_clk);
        test_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        p = pulses;
        feed(32'h9B, 1);
        repeat (12) @(posedge sys_clk);
        #1 chk(pulses == p, 1);
        @(posedge sys_clk);
        test_n <= 1'b0;
        wait_dec(1);
        repeat (6) @(posedge sys_clk);
        feed(32'h9B, 1);
        wait_dec(1);
        close_out();
    end
endmodule // test_cpu_ctl_decode
bind cpu_ctl_decode cpu_ctl_decode_chk #(.EA_CLKS(EA_CLKS), .WAIT_CLKS(WAIT_CLKS)) i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
    .test_n(test_n), .intr(intr), .dec_valid(dec_valid), .dec(dec), .flags(flags), .halted(halted));
